/* File: verilog/delayed_toggle_timer.sv */
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "dtt_params.svh"

module delayed_toggle_timer
#(
  parameter int unsigned CYC_10MS = `DTT_CYC(`DTT_TB10_MS),
  parameter int unsigned CYC_100MS = `DTT_CYC(`DTT_TB100_MS),
  parameter int unsigned CYC_1S = `DTT_CYC(`DTT_TB1S_MS)
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DTT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trig_in,
  input wire logic clear_in,
  output logic bit_out,
  output logic [`DTT_CNT_W-1:0] delay_word,
  output logic [`DTT_CNT_W-1:0] elapsed_word
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic trig_lvl; // Filtered trigger
  logic clr_lvl; // Filtered clear
  logic trig_prev_reg; // Trigger one cycle ago, for edge detect
  logic trig_rise; // Accepted rising edge
  logic [`DTT_SEL_W-1:0] sel_reg; // Time base field as written
  dtt_pkg::run_state_e state_reg; // Sequencer state
  logic [`DTT_CNT_W-1:0] next_count; // Elapsed plus one tick
  logic access; // APB access phase, answer due this edge
  logic mapped; // Address hits a register
  logic [31:0] rd_mux; // Read data before capture
  tick_if tb ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and time base

  pin_sync u_trig_sync
  (
    .clk(pclk),
    .rst_n(presetn),
    .pin(trig_in),
    .level(trig_lvl)
  );

  pin_sync u_clr_sync
  (
    .clk(pclk),
    .rst_n(presetn),
    .pin(clear_in),
    .level(clr_lvl)
  );

  time_base_gen
  #(
    .CYC_10MS(CYC_10MS),
    .CYC_100MS(CYC_100MS),
    .CYC_1S(CYC_1S)
  )
  u_time_base
  (
    .clk(pclk),
    .rst_n(presetn),
    .tb(tb.gen)
  );

  // Decode the written field; the spare code falls back to the slowest base
  always_comb
  begin
    case (sel_reg)
      2'h0: tb.sel = dtt_pkg::TB_10MS;
      2'h1: tb.sel = dtt_pkg::TB_100MS;
      default: tb.sel = dtt_pkg::TB_1S;
    endcase
  end

  // A fresh start realigns the prescaler so the first tick is a full period
  assign tb.restart = trig_rise | clr_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detect

  // Previous trigger level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trig_prev_reg <= 1'b0;
    else
      trig_prev_reg <= trig_lvl;
  end

  // Only a low-to-high change starts timing, never a steady high
  assign trig_rise = trig_lvl & ~trig_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Delay sequencer

  // Count after one more tick; it stops at the delay, so it never wraps
  assign next_count = elapsed_word + 15'h0001;

  // State, elapsed count and toggled output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= dtt_pkg::ST_IDLE;
      elapsed_word <= 15'h0000;
      bit_out <= 1'b0;
    end
    else if (clr_lvl)
    begin
      // Clear wins over everything, including a trigger edge
      state_reg <= dtt_pkg::ST_IDLE;
      elapsed_word <= 15'h0000;
      bit_out <= 1'b0;
    end
    else if (trig_rise)
    begin
      elapsed_word <= 15'h0000;
      if (delay_word == 15'h0000)
      begin
        // Zero delay: count already reached, toggle at once
        state_reg <= dtt_pkg::ST_IDLE;
        bit_out <= ~bit_out;
      end
      else
        state_reg <= dtt_pkg::ST_TIMING;
    end
    else
    begin
      case (state_reg)
        dtt_pkg::ST_TIMING:
        begin
          if (tb.tick)
          begin
            // >= guards against a delay lowered while timing
            if (next_count >= delay_word)
            begin
              elapsed_word <= next_count;
              bit_out <= ~bit_out;
              state_reg <= dtt_pkg::ST_IDLE;
            end
            else
              elapsed_word <= next_count;
          end
        end
        // Idle holds the reached count until the next edge
        default: state_reg <= dtt_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state per access

  // Completing edge of an access: select, enable and the raised ready
  assign access = psel & penable & pready;
  assign mapped = (paddr == `DTT_CTRL_OFS) || (paddr == `DTT_DELAY_OFS) ||
                  (paddr == `DTT_ELAPSED_OFS) || (paddr == `DTT_STATUS_OFS);

  // Read selection; unmapped and reserved bits read zero
  always_comb
  begin
    rd_mux = 32'h00000000;
    case (paddr)
      `DTT_CTRL_OFS: rd_mux[`DTT_SEL_W-1:0] = sel_reg;
      `DTT_DELAY_OFS: rd_mux[`DTT_CNT_W-1:0] = delay_word;
      `DTT_ELAPSED_OFS: rd_mux[`DTT_CNT_W-1:0] = elapsed_word;
      `DTT_STATUS_OFS:
      begin
        rd_mux[`DTT_STAT_OUT_BIT] = bit_out;
        rd_mux[`DTT_STAT_RUN_BIT] = (state_reg == dtt_pkg::ST_TIMING);
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Answer one cycle into the access phase, with registered data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rd_mux;
    end
  end

  // Writable configuration, taken at the edge that completes the access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_reg <= `DTT_SEL_RST;
      delay_word <= `DTT_DELAY_RST;
    end
    else if (access && pwrite)
    begin
      if (paddr == `DTT_CTRL_OFS)
        sel_reg <= pwdata[`DTT_SEL_W-1:0];
      if (paddr == `DTT_DELAY_OFS)
        delay_word <= pwdata[`DTT_CNT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Clear forces the count to zero and the output off on the next edge
  AST_CLEAR_ZEROES: assert property (
    clr_lvl |=> elapsed_word == 15'h0000 && !bit_out)
    else $error("clear did not zero count and output");

  // Idle with no edge stays idle, so a steady high starts nothing
  AST_NO_LEVEL_START: assert property (
    state_reg == dtt_pkg::ST_IDLE && !trig_rise && !clr_lvl
    |=> state_reg == dtt_pkg::ST_IDLE)
    else $error("timing started without a rising edge");

  // An accepted edge with a non-zero delay starts from zero
  AST_RESTART_ZERO: assert property (
    trig_rise && !clr_lvl && delay_word != 15'h0000
    |=> elapsed_word == 15'h0000 && state_reg == dtt_pkg::ST_TIMING)
    else $error("edge did not restart count from zero");

  // The tick that brings the count to the delay flips the output
  AST_TOGGLE_AT_DELAY: assert property (
    state_reg == dtt_pkg::ST_TIMING && tb.tick && !clr_lvl && !trig_rise &&
    next_count == delay_word
    |=> bit_out != $past(bit_out) && state_reg == dtt_pkg::ST_IDLE)
    else $error("output did not toggle at delay");

  // Idle holds the reached count and the output level
  AST_HOLD_AT_DELAY: assert property (
    state_reg == dtt_pkg::ST_IDLE && !trig_rise && !clr_lvl
    |=> $stable(elapsed_word) && $stable(bit_out))
    else $error("count or output moved while idle");

  // Between ticks the elapsed count does not move
  AST_TICK_ONLY: assert property (
    state_reg == dtt_pkg::ST_TIMING && !tb.tick && !trig_rise && !clr_lvl
    |=> $stable(elapsed_word))
    else $error("count advanced without a time base tick");

  // Elapsed read returns the count captured one cycle earlier
  AST_READ_ELAPSED: assert property (
    access && !pwrite && paddr == `DTT_ELAPSED_OFS
    |-> prdata == {17'h00000, $past(elapsed_word)})
    else $error("elapsed read returned wrong value");

  // A completed write to the delay register lands on that edge
  AST_DELAY_WRITE: assert property (
    access && pwrite && paddr == `DTT_DELAY_OFS
    |=> delay_word == $past(pwdata[`DTT_CNT_W-1:0]))
    else $error("delay write not stored");

  // Every access phase sees exactly one wait state
  AST_ONE_WAIT: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");

  // Zero delay: the accepted edge flips the output at once
  AST_ZERO_DELAY_TOGGLE: assert property (
    trig_rise && !clr_lvl && delay_word == 15'h0000
    |=> bit_out != $past(bit_out) && state_reg == dtt_pkg::ST_IDLE)
    else $error("zero delay did not toggle at once");

  // Clear also stops timing, so no later tick can flip the output
  AST_CLEAR_STOPS: assert property (
    clr_lvl |=> state_reg == dtt_pkg::ST_IDLE)
    else $error("clear left the sequencer timing");

  // The error answer matches the address decode of the access
  AST_ERR_UNMAPPED: assert property (
    psel && penable && !pready |=> pslverr == !$past(mapped))
    else $error("error answer does not match address decode");

  // Cover points for the main scenarios
  COV_ELAPSED_READ: cover property (access && !pwrite &&
    paddr == `DTT_ELAPSED_OFS);
  COV_TOGGLE_ON: cover property (!bit_out ##1 bit_out);
  COV_TOGGLE_OFF: cover property (bit_out && !clr_lvl ##1 !bit_out);
  COV_CLEAR_TIMING: cover property (state_reg == dtt_pkg::ST_TIMING && clr_lvl);
  COV_ZERO_DELAY: cover property (trig_rise && delay_word == 15'h0000);

endmodule : delayed_toggle_timer

/* File: verilog/dtt_params.svh */
`ifndef DTT_PARAMS_SVH
`define DTT_PARAMS_SVH

// Clock rate in kHz, so one millisecond is this many cycles
`define DTT_CLK_KHZ 50000
// Time base periods in milliseconds
`define DTT_TB10_MS 10
`define DTT_TB100_MS 100
`define DTT_TB1S_MS 1000
// Cycles for a period given in milliseconds
`define DTT_CYC(ms) ((ms) * `DTT_CLK_KHZ)

// Register byte offsets
`define DTT_ADDR_W 12
`define DTT_CTRL_OFS 12'h000
`define DTT_DELAY_OFS 12'h004
`define DTT_ELAPSED_OFS 12'h008
`define DTT_STATUS_OFS 12'h00C

// Field layout and reset values
`define DTT_CNT_W 15
`define DTT_SEL_W 2
`define DTT_SEL_RST 2'h0
`define DTT_DELAY_RST 15'h0000
`define DTT_STAT_OUT_BIT 0
`define DTT_STAT_RUN_BIT 1

`endif

/* File: verilog/dtt_pkg.sv */
package dtt_pkg;

  // Selectable time base
  typedef enum logic [1:0] {TB_10MS, TB_100MS, TB_1S} timebase_e;

  // Delay sequencer states
  typedef enum logic {ST_IDLE, ST_TIMING} run_state_e;

endpackage : dtt_pkg

/* File: verilog/tick_if.sv */
`timescale 1ns/1ps

// Time base selection, restart and tick between sequencer and prescaler
interface tick_if;
  dtt_pkg::timebase_e sel;
  logic restart;
  logic tick;

  modport gen (input sel, input restart, output tick);
  modport user (output sel, output restart, input tick);
endinterface : tick_if

/* File: verilog/pin_sync.sv */
`timescale 1ns/1ps

// Three-stage synchroniser with agreement filter for one pin
module pin_sync
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic level
);

  logic s1_reg; // Metastability stage, read only by s2_reg
  logic s2_reg;
  logic s3_reg;

  // Shift chain
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      level <= 1'b0;
    else if (s2_reg == s3_reg)
      level <= s3_reg;
  end

endmodule : pin_sync

/* File: verilog/time_base_gen.sv */
`timescale 1ns/1ps
`include "dtt_params.svh"

// Prescaler giving one tick pulse per period of the selected time base
module time_base_gen
#(
  parameter int unsigned CYC_10MS = `DTT_CYC(`DTT_TB10_MS),
  parameter int unsigned CYC_100MS = `DTT_CYC(`DTT_TB100_MS),
  parameter int unsigned CYC_1S = `DTT_CYC(`DTT_TB1S_MS)
)
(
  input wire logic clk,
  input wire logic rst_n,
  tick_if.gen tb
);

  logic [25:0] cnt_reg; // Cycles elapsed in the present period
  logic [25:0] limit; // Last count of a period

  // Period length for the chosen base
  always_comb
  begin
    case (tb.sel)
      dtt_pkg::TB_10MS: limit = 26'(CYC_10MS - 1);
      dtt_pkg::TB_100MS: limit = 26'(CYC_100MS - 1);
      default: limit = 26'(CYC_1S - 1);
    endcase
  end

  // Counter; restart aligns the first tick to a full period after a start
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 26'h0000000;
      tb.tick <= 1'b0;
    end
    else if (tb.restart)
    begin
      cnt_reg <= 26'h0000000;
      tb.tick <= 1'b0;
    end
    else if (cnt_reg >= limit)
    begin
      // >= also covers a base switched to a shorter one mid-period
      cnt_reg <= 26'h0000000;
      tb.tick <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 26'h0000001;
      tb.tick <= 1'b0;
    end
  end

endmodule : time_base_gen

/* File: tb/trig_src.sv */
`timescale 1ns/1ps

// Far-side logic that drives the trigger and clear pins of the timer
module trig_src
(
  input wire logic clk,
  output logic trig,
  output logic clr
);
  // Both pins idle low from time zero
  initial
  begin
    trig = 1'b0;
    clr = 1'b0;
  end

  // Change both pin levels just after an edge; they then hold as levels
  task drive(input logic t, input logic c);
    @(posedge clk);
    trig <= t;
    clr <= c;
  endtask : drive
endmodule : trig_src

/* File: tb/delayed_toggle_timer_bench.sv */
`timescale 1ns/1ps
`include "dtt_params.svh"

module delayed_toggle_timer_bench;
  // Short prescaler counts keep the run brief
  localparam int C10 = 4;
  localparam int C100 = 8;
  localparam int C1S = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic trig_in, clear_in, bit_out, err;
  logic [`DTT_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [`DTT_CNT_W-1:0] delay_word, elapsed_word;
  int fails, n_tests, seed, i, dl_r;

  //////////////////////////////////////////////////////////////////////
  // Clock and instances
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  delayed_toggle_timer #(.CYC_10MS(C10), .CYC_100MS(C100), .CYC_1S(C1S))
  uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_in(trig_in),
    .clear_in(clear_in), .bit_out(bit_out), .delay_word(delay_word),
    .elapsed_word(elapsed_word));

  trig_src far (.clk(pclk), .trig(trig_in), .clr(clear_in));

  //////////////////////////////////////////////////////////////////////
  // Helpers
  // Tick period in cycles for a time base code
  function int tick_cyc(input int code);
    return (code == 0) ? C10 : (code == 1) ? C100 : C1S;
  endfunction : tick_cyc

  // Compare one result and count it
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask : chk

  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic wr, input logic [`DTT_ADDR_W-1:0] a,
    input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb

  // Configure, raise the trigger, time the toggle, then hold high
  task run(input int code, input int dl);
    int k;
    logic b0;
    apb(1'b1, `DTT_CTRL_OFS, code);
    apb(1'b1, `DTT_DELAY_OFS, dl);
    chk("delay_word", dl, delay_word);
    b0 = bit_out;
    far.drive(1'b1, 1'b0);
    k = 0;
    while (bit_out === b0 && k < 2000)
    begin
      @(posedge pclk);
      k++;
      // Old count is dropped well before the first tick
      if (k == 7 && code > 0)
        chk("restart", 0, elapsed_word);
    end
    chk("delay_ok", 1, k >= dl * tick_cyc(code) &&
      k <= dl * tick_cyc(code) + 10);
    @(negedge pclk);
    chk("bit_out", !b0, bit_out);
    // A steady high level must neither retrigger nor count on
    repeat (3 * tick_cyc(code)) @(posedge pclk);
    chk("hold_bit", !b0, bit_out);
    chk("hold_cnt", dl, elapsed_word);
    apb(1'b0, `DTT_ELAPSED_OFS, 0);
    chk("elapsed_rd", dl, rd);
    // Status: output level in bit 0, timing bit 1 clear now that timing has stopped
    apb(1'b0, `DTT_STATUS_OFS, 0);
    chk("status", 32'(!b0), rd);
    far.drive(1'b0, 1'b0);
    repeat (6) @(posedge pclk);
  endtask : run

  // Print the counts and the verdict, then stop
  task wrap_up();
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    seed = 32'h05A7;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("rst_bit", 0, bit_out);
    // Largest delay fits; bits above the field are dropped
    apb(1'b1, `DTT_DELAY_OFS, 32'hFFFFFFFF);
    apb(1'b0, `DTT_DELAY_OFS, 0);
    chk("delay_max", 32'h00007FFF, rd);
    // Unmapped address is refused; read-only write is not
    apb(1'b0, 12'h010, 0);
    chk("unmapped", 1, err);
    apb(1'b1, `DTT_ELAPSED_OFS, 32'h00000005);
    chk("ro_write", 0, err);
    // Every time base with random delays, then zero delay
    // Random delays stay at one tick or more, never below a scan
    for (i = 0; i < 3; i++)
    begin
      dl_r = 1 + ($unsigned($random(seed)) % 3);
      run(i, dl_r);
    end
    run(0, 0);
    // Spare time base code falls back to the slowest base
    run(3, 2);
    // Start timing, then clear in mid-delay with the output still ON
    far.drive(1'b1, 1'b0);
    repeat (24) @(posedge pclk);
    chk("mid_cnt", 1, elapsed_word);
    // Clear held: count zeroed, output off, triggers ignored
    far.drive(1'b0, 1'b1);
    repeat (8) @(posedge pclk);
    chk("clr_bit", 0, bit_out);
    chk("clr_cnt", 0, elapsed_word);
    far.drive(1'b1, 1'b1);
    repeat (3 * C100) @(posedge pclk);
    chk("clr_trig", 0, bit_out);
    far.drive(1'b0, 1'b0);
    wrap_up();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    wrap_up();
  end
endmodule : delayed_toggle_timer_bench
